// [design/ilc_peak_det.sv]
// Peak and zero-cross detector over the selected ADC channels
`timescale 1ns/1ns
module ilc_peak_det
  import ilc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Sample stream, index 0 right, 1 left
  input wire logic [ilc_pkg::SMP_W-1:0] smp_r,
  input wire logic [ilc_pkg::SMP_W-1:0] smp_l,
  input wire logic smp_valid,
  input wire logic [1:0] chan_on,
  // Detector results
  output logic [ilc_pkg::MAG_W-1:0] peak_q,
  output logic [ilc_pkg::MAG_W-1:0] inst_q,
  output logic zc_q,
  output logic tick_q
);
  logic [SMP_W-1:0] smp [2];
  logic [MAG_W-1:0] mag [2];
  logic [1:0] sign_q;
  logic [1:0] flip;
  logic [MAG_W-1:0] inst_d;
  logic [MAG_W-1:0] decayed;

  assign smp[0] = smp_r;
  assign smp[1] = smp_l;

  // Per-channel magnitude and sign change
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    assign mag[c] = !smp[c][SMP_W-1] ? smp[c][MAG_W-1:0] :
                    (smp[c][MAG_W-1:0] == '0) ? {MAG_W{1'b1}} : MAG_W'(-smp[c]);
    assign flip[c] = chan_on[c] & (sign_q[c] != smp[c][SMP_W-1]);
    always_ff @(posedge sys_clk)
    begin
      if (srst)
        sign_q[c] <= 1'b0;
      else if (smp_valid)
        sign_q[c] <= smp[c][SMP_W-1];
    end
  end

  // Largest magnitude among enabled channels, peak decays slowly
  always_comb
  begin
    inst_d = '0;
    if (chan_on[0])
      inst_d = mag[0];
    if (chan_on[1] && mag[1] > inst_d)
      inst_d = mag[1];
    decayed = peak_q - (peak_q >> PEAK_DECAY_SH);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      peak_q <= '0;
      inst_q <= '0;
      zc_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= smp_valid;
      zc_q <= smp_valid & (|flip);
      if (smp_valid)
      begin
        inst_q <= inst_d;
        peak_q <= (inst_d > decayed) ? inst_d : decayed;
      end
    end
  end
endmodule

// [design/ilc_pkg.sv]
// Package: register map, field layout, timing and tables of the input level controller
package ilc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned GAIN_W = 6;
  localparam int unsigned SMP_W = 16;
  localparam int unsigned MAG_W = 15;
  localparam int unsigned CNT_W = 17;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CFG1 = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_CFG2 = 7'h21;
  localparam logic [ADDR_W-1:0] ADDR_CFG3 = 7'h22;
  localparam logic [ADDR_W-1:0] ADDR_NG = 7'h23;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 7'h24;
  localparam logic [DATA_W-1:0] RST_CFG1 = 9'h038;
  localparam logic [DATA_W-1:0] RST_CFG2 = 9'h00b;
  localparam logic [DATA_W-1:0] RST_CFG3 = 9'h032;
  localparam logic [DATA_W-1:0] RST_NG = 9'h000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_MIN_LO = 0;
  localparam int unsigned F_MIN_HI = 2;
  localparam int unsigned F_MAX_LO = 3;
  localparam int unsigned F_MAX_HI = 5;
  localparam int unsigned F_SEL_LO = 7;
  localparam int unsigned F_SEL_HI = 8;
  localparam int unsigned F_LVL_LO = 0;
  localparam int unsigned F_LVL_HI = 3;
  localparam int unsigned F_HLD_LO = 4;
  localparam int unsigned F_HLD_HI = 7;
  localparam int unsigned F_ZC = 8;
  localparam int unsigned F_ATK_LO = 0;
  localparam int unsigned F_ATK_HI = 3;
  localparam int unsigned F_DCY_LO = 4;
  localparam int unsigned F_DCY_HI = 7;
  localparam int unsigned F_MODE = 8;
  localparam int unsigned F_NOISE_GATE_THRESHOLD_LO = 0;
  localparam int unsigned F_NOISE_GATE_THRESHOLD_HI = 2;
  localparam int unsigned F_NGEN = 3;

  // ----------------------------------------------------------------
  // Gain codes: 0.75 dB per code, code 0 is -12 dB
  // ----------------------------------------------------------------
  localparam logic [GAIN_W-1:0] GAIN_RST = 6'h10;
  localparam logic [2:0] FLOOR_FILL = 3'h0;
  localparam logic [2:0] CEIL_FILL = 3'h7;
  localparam logic [MAG_W-1:0] CLIP_MAG = 15'h7000;
  localparam int unsigned PEAK_DECAY_SH = 4;
  localparam logic [3:0] RATE_CODE_MAX = 4'ha;
  localparam logic [3:0] HLD_CODE_MAX = 4'ha;
  localparam logic [8:0] NG_FS_U = 9'h070;
  localparam logic [8:0] NG_OFS_U = 9'h044;

  // ----------------------------------------------------------------
  // Step times, counted in samples of the nominal rate
  // ----------------------------------------------------------------
  localparam int unsigned SMP_PERIOD_NS = 20833;
  localparam int unsigned T_ATK_NORM_NS = 104000;
  localparam int unsigned T_DCY_NORM_NS = 410000;
  localparam int unsigned T_ATK_LIM_NS = 22700;
  localparam int unsigned T_DCY_LIM_NS = 90800;
  localparam int unsigned T_HLD_NS = 2670000;
  localparam logic [CNT_W-1:0] ATK_NORM_SMP = CNT_W'((T_ATK_NORM_NS + SMP_PERIOD_NS - 1) / SMP_PERIOD_NS);
  localparam logic [CNT_W-1:0] DCY_NORM_SMP = CNT_W'((T_DCY_NORM_NS + SMP_PERIOD_NS - 1) / SMP_PERIOD_NS);
  localparam logic [CNT_W-1:0] ATK_LIM_SMP = CNT_W'((T_ATK_LIM_NS + SMP_PERIOD_NS - 1) / SMP_PERIOD_NS);
  localparam logic [CNT_W-1:0] DCY_LIM_SMP = CNT_W'((T_DCY_LIM_NS + SMP_PERIOD_NS - 1) / SMP_PERIOD_NS);
  localparam logic [CNT_W-1:0] HLD_SMP = CNT_W'((T_HLD_NS + SMP_PERIOD_NS - 1) / SMP_PERIOD_NS);

  // Controller states, Gray coded along off, hold, up, down
  typedef enum logic [1:0] {ST_OFF = 2'b00, ST_HOLD = 2'b01, ST_UP = 2'b11, ST_DOWN = 2'b10} ilc_state_t;

  // Target magnitude for each level code, -21 dBFS to -1.5 dBFS
  function automatic logic [MAG_W-1:0] target_mag(input logic [3:0] code);
    logic [MAG_W-1:0] m;
    unique case (code)
      4'h0, 4'h1: m = 15'h0b68;
      4'h2: m = 15'h0d8e;
      4'h3: m = 15'h101d;
      4'h4: m = 15'h1324;
      4'h5: m = 15'h16c3;
      4'h6: m = 15'h1b09;
      4'h7: m = 15'h2021;
      4'h8: m = 15'h262a;
      4'h9: m = 15'h2d58;
      4'ha: m = 15'h35dc;
      4'hb: m = 15'h4027;
      4'hc: m = 15'h4c38;
      4'hd: m = 15'h5a9d;
      4'he, 4'hf: m = 15'h6ba2;
    endcase
    return m;
  endfunction

endpackage

// [design/ilc_step_timer.sv]
// Sample-counting timer that marks the end of each step or hold period
`timescale 1ns/1ns
module ilc_step_timer
  import ilc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic restart,
  input wire logic adv,
  input wire logic [ilc_pkg::CNT_W-1:0] period,
  // Result
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;

  // Period end reached on this sample
  assign tick = adv & (cnt_q >= period - CNT_W'(1));

  always_ff @(posedge sys_clk)
  begin
    if (srst || restart)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= '0;
    else if (adv)
      cnt_q <= cnt_q + CNT_W'(1);
  end
endmodule

// [design/ilc_top.sv]
// Automatic input level controller steering the input amplifier gain code
//
// Overview of operation
// - Peak above target lowers gain at attack rate; below raises at decay rate.
// - Four-bit target: code 1011 is -6dBFS, 1.5dB per code, -21 to -1.5dBFS.
// - Channel select bits 8:7: off, right only, left only, both.
// - Gain floor: -12dB at 000 up 6dB per code to +30dB.
// - Gain ceiling: -6.75dB at 000 up 6dB per code to +35.25dB.
// - Floor and ceiling act only while control is on.
// - Gain outside floor-to-ceiling is moved back into range at once.
// - Disabled: amplifier keeps last gain, changes only by manual gain writes.
// - Mode bit 8 of third register: 0 normal, 1 limiter, picks timing table.
// - Limiter never raises gain above gain at enable or mode switch, unless that gain is below the floor.
// - Normal attack step 104us at code 0, doubling per code, capped at 1010.
// - Normal decay step 410us at code 0, doubling per code, capped at 1010.
// - Limiter steps: attack 22.7us, decay 90.8us at code 0, doubling.
// - All timing counts sample strobes, so times follow sample rate.
// - Normal mode hold delays gain rise: 0 none, 2.67ms doubling to 1.37s.
// - Signal above target during hold abandons hold; expiry starts gain rise.
// - Input above 87.5% full scale forces fastest attack until it drops.
// - Noise gate freezes gain while level is below threshold plus gains.
// - Gate threshold: -39dB at 000 to -81dB at 111, about 6dB steps.
// - Noise gate works only in normal mode.
// - Zero-cross bit 8 of second register makes steps wait for zero crossing.
// - Bit 3 of gate register enables noise gate, reset disabled.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module ilc_top
  import ilc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [ilc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ilc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ilc_pkg::DATA_W-1:0] reg_rdata,
  // ADC sample stream
  input wire logic [ilc_pkg::SMP_W-1:0] smp_l,
  input wire logic [ilc_pkg::SMP_W-1:0] smp_r,
  input wire logic smp_valid,
  // Manual input gain setting and its write pulses
  input wire logic [ilc_pkg::GAIN_W-1:0] manual_input_gain_l,
  input wire logic [ilc_pkg::GAIN_W-1:0] manual_input_gain_r,
  input wire logic manual_gain_wr_l,
  input wire logic manual_gain_wr_r,
  input wire logic [ilc_pkg::GAIN_W-1:0] mic_boost_gain,
  // Amplifier gain codes
  output logic [ilc_pkg::GAIN_W-1:0] pga_gain_l,
  output logic [ilc_pkg::GAIN_W-1:0] pga_gain_r
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] cfg1_q, cfg2_q, cfg3_q, ng_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] levelling_channel_select;
  logic [2:0] gain_floor, gain_ceiling, noise_gate_threshold;
  logic [3:0] level_target, rampup_hold_time, gain_rampup_rate, gain_rampdown_rate;
  logic zero_cross_gating, levelling_mode_select, noise_gate_enable;
  logic active, active_q, mode_q, en_rise;
  logic [MAG_W-1:0] peak, inst;
  logic zc, pk_tick, clip, over, gated, tmr_tick, restart, apply, pend_q;
  logic [GAIN_W-1:0] ctl_gain_q, start_q, lo, hi_raw, hi, man_sel;
  logic [GAIN_W-1:0] gain_q [2];
  logic [GAIN_W-1:0] man_gain [2];
  logic [1:0] man_wr;
  logic [3:0] atk_c, dcy_c, hld_c, lvl_msb;
  logic [CNT_W-1:0] period;
  logic [8:0] ng_lhs, ng_rhs;
  ilc_state_t st_q, st_d;

  // Leading one position of a magnitude, a 6 dB level estimate
  function automatic logic [3:0] msb_pos(input logic [MAG_W-1:0] m);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < MAG_W; i++)
      if (m[i])
        p = 4'(i);
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Configuration writes
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cfg1_q <= RST_CFG1;
      cfg2_q <= RST_CFG2;
      cfg3_q <= RST_CFG3;
      ng_q <= RST_NG;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_CFG1)
        cfg1_q <= reg_wdata;
      if (reg_addr == ADDR_CFG2)
        cfg2_q <= reg_wdata;
      if (reg_addr == ADDR_CFG3)
        cfg3_q <= reg_wdata;
      if (reg_addr == ADDR_NG)
        ng_q <= {5'h00, reg_wdata[F_NGEN:0]}; // Upper gate bits unused
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge sys_clk)
  begin
    if (srst || !reg_rd)
      rdata_q <= '0;
    else
      unique case (reg_addr)
        ADDR_CFG1: rdata_q <= cfg1_q;
        ADDR_CFG2: rdata_q <= cfg2_q;
        ADDR_CFG3: rdata_q <= cfg3_q;
        ADDR_NG: rdata_q <= ng_q;
        ADDR_STAT: rdata_q <= {gated, st_q, ctl_gain_q};
        default: rdata_q <= '0;
      endcase
  end
  assign reg_rdata = rdata_q;

  // Field extraction
  assign levelling_channel_select = cfg1_q[F_SEL_HI:F_SEL_LO];
  assign gain_floor = cfg1_q[F_MIN_HI:F_MIN_LO];
  assign gain_ceiling = cfg1_q[F_MAX_HI:F_MAX_LO];
  assign level_target = cfg2_q[F_LVL_HI:F_LVL_LO];
  assign rampup_hold_time = cfg2_q[F_HLD_HI:F_HLD_LO];
  assign zero_cross_gating = cfg2_q[F_ZC];
  assign gain_rampdown_rate = cfg3_q[F_ATK_HI:F_ATK_LO];
  assign gain_rampup_rate = cfg3_q[F_DCY_HI:F_DCY_LO];
  assign levelling_mode_select = cfg3_q[F_MODE];
  assign noise_gate_threshold = ng_q[F_NOISE_GATE_THRESHOLD_HI:F_NOISE_GATE_THRESHOLD_LO];
  assign noise_gate_enable = ng_q[F_NGEN];

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  ilc_peak_det u_peak (
    .sys_clk(sys_clk),
    .srst(srst),
    .smp_r(smp_r),
    .smp_l(smp_l),
    .smp_valid(smp_valid),
    .chan_on(levelling_channel_select),
    .peak_q(peak),
    .inst_q(inst),
    .zc_q(zc),
    .tick_q(pk_tick)
  );

  // Target, clip and noise gate decisions
  always_comb
  begin
    clip = inst > CLIP_MAG;
    over = (peak > target_mag(level_target)) | clip;
    lvl_msb = msb_pos(peak);
    ng_lhs = {2'b00, lvl_msb, 3'b000} + {3'b000, noise_gate_threshold, 3'b000} + NG_OFS_U;
    ng_rhs = NG_FS_U + {3'b000, ctl_gain_q} + {3'b000, mic_boost_gain};
    gated = noise_gate_enable & !levelling_mode_select & !over &
            ((peak == '0) | (ng_lhs < ng_rhs));
  end

  // ----------------------------------------------------------------
  // Enable and limits
  // ----------------------------------------------------------------
  assign active = levelling_channel_select != 2'b00;
  assign en_rise = active & !active_q;
  assign man_gain[0] = manual_input_gain_r;
  assign man_gain[1] = manual_input_gain_l;
  assign man_wr = {manual_gain_wr_l, manual_gain_wr_r};
  assign man_sel = levelling_channel_select[1] ? manual_input_gain_l : manual_input_gain_r;

  // Floor and ceiling codes, limiter caps at the starting gain
  always_comb
  begin
    lo = {gain_floor, FLOOR_FILL};
    hi_raw = {gain_ceiling, CEIL_FILL};
    if (levelling_mode_select && start_q < hi_raw)
      hi_raw = start_q;
    hi = (hi_raw < lo) ? lo : hi_raw;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      active_q <= 1'b0;
      mode_q <= 1'b0;
    end
    else
    begin
      active_q <= active;
      mode_q <= levelling_mode_select;
    end
  end

  // Starting gain captured at enable or at switch into limiter mode
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      start_q <= GAIN_RST;
    else if (en_rise)
      start_q <= man_sel;
    else if (active && levelling_mode_select && !mode_q)
      start_q <= ctl_gain_q;
  end

  // ----------------------------------------------------------------
  // Step timing
  // ----------------------------------------------------------------
  // Step or hold period in samples for the current state
  always_comb
  begin
    atk_c = (gain_rampdown_rate > RATE_CODE_MAX) ? RATE_CODE_MAX : gain_rampdown_rate;
    dcy_c = (gain_rampup_rate > RATE_CODE_MAX) ? RATE_CODE_MAX : gain_rampup_rate;
    hld_c = (rampup_hold_time > HLD_CODE_MAX) ? HLD_CODE_MAX : rampup_hold_time;
    if (st_q == ST_HOLD)
      period = HLD_SMP << (hld_c - 4'h1);
    else if (st_q == ST_UP)
      period = (levelling_mode_select ? DCY_LIM_SMP : DCY_NORM_SMP) << dcy_c;
    else if (clip)
      period = levelling_mode_select ? ATK_LIM_SMP : ATK_NORM_SMP;
    else
      period = (levelling_mode_select ? ATK_LIM_SMP : ATK_NORM_SMP) << atk_c;
  end

  // Timer advances once per sample
  ilc_step_timer u_tmr (
    .sys_clk(sys_clk),
    .srst(srst),
    .restart(restart),
    .adv(pk_tick),
    .period(period),
    .tick(tmr_tick)
  );

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (!active)
      st_d = ST_OFF;
    else if (pk_tick)
    begin
      if (over)
        st_d = ST_DOWN;
      else
        unique case (st_q)
          ST_OFF, ST_DOWN: st_d = (!levelling_mode_select && rampup_hold_time != 4'h0) ? ST_HOLD : ST_UP;
          ST_HOLD: st_d = (levelling_mode_select || tmr_tick) ? ST_UP : ST_HOLD;
          ST_UP: st_d = ST_UP;
        endcase
    end
  end
  assign restart = st_d != st_q;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_q <= ST_OFF;
    else
      st_q <= st_d;
  end

  // Step taken at period end, optionally deferred to a zero crossing
  assign apply = (tmr_tick | pend_q) & (!zero_cross_gating | zc) & !gated &
                 ((st_q == ST_UP) | (st_q == ST_DOWN));

  // A period end that could not be used waits here
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pend_q <= 1'b0;
    else if (tmr_tick && !apply)
      pend_q <= 1'b1;
    else if (restart || apply)
      pend_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Controlled gain
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ctl_gain_q <= GAIN_RST;
    else if (en_rise)
      ctl_gain_q <= man_sel;
    else if (active)
    begin
      if (ctl_gain_q < lo)
        ctl_gain_q <= lo;
      else if (ctl_gain_q > hi)
        ctl_gain_q <= hi;
      else if (apply && st_q == ST_DOWN && ctl_gain_q > lo)
        ctl_gain_q <= ctl_gain_q - GAIN_W'(1);
      else if (apply && st_q == ST_UP && ctl_gain_q < hi)
        ctl_gain_q <= ctl_gain_q + GAIN_W'(1);
    end
  end

  // Per-channel amplifier code: follows control, else holds or takes manual writes
  for (genvar c = 0; c < 2; c++)
  begin : g_out
    always_ff @(posedge sys_clk)
    begin
      if (srst)
        gain_q[c] <= GAIN_RST;
      else if (levelling_channel_select[c] && !en_rise)
        gain_q[c] <= ctl_gain_q;
      else if (!levelling_channel_select[c] && man_wr[c])
        gain_q[c] <= man_gain[c];
    end
  end
  assign pga_gain_r = gain_q[0];
  assign pga_gain_l = gain_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_range_clamp: assert property (active && !en_rise && ctl_gain_q < lo |=> ctl_gain_q == $past(lo))
    else $error("gain below floor not clamped");
  a_off_keeps_gain: assert property (!levelling_channel_select[0] && !manual_gain_wr_r |=> $stable(pga_gain_r))
    else $error("right gain moved while uncontrolled");
  a_enable_loads: assert property ($rose(active) |=> ctl_gain_q == $past(man_sel))
    else $error("enable did not load manual gain");
  a_limiter_cap: assert property (active && !en_rise && levelling_mode_select && mode_q && lo <= start_q
                                  && ctl_gain_q <= start_q |=> ctl_gain_q <= start_q)
    else $error("limiter raised gain above start");
  a_attack_step: assert property (active && !en_rise && apply && st_q == ST_DOWN && ctl_gain_q > lo
                                  && ctl_gain_q <= hi |=> ctl_gain_q == $past(ctl_gain_q) - GAIN_W'(1))
    else $error("attack step missing");
  a_zc_wait: assert property (active && zero_cross_gating && !zc && !en_rise && ctl_gain_q >= lo
                              && ctl_gain_q <= hi ##1 active |-> $stable(ctl_gain_q))
    else $error("gain changed away from zero crossing");
  a_gate_freeze: assert property (active && gated && !en_rise && ctl_gain_q >= lo && ctl_gain_q <= hi
                                  |=> ctl_gain_q == $past(ctl_gain_q))
    else $error("gain moved while gated");
  a_hold_wait: assert property (st_q == ST_HOLD && !(pk_tick && tmr_tick) && !levelling_mode_select
                                |=> st_q != ST_UP)
    else $error("hold left early");
  a_clip_fast: assert property (st_q == ST_DOWN && clip && !levelling_mode_select
                                |-> period == ATK_NORM_SMP)
    else $error("clip not at fastest attack");
  a_read_lat: assert property (reg_rd && reg_addr == ADDR_CFG3 |=> reg_rdata == $past(cfg3_q))
    else $error("read data wrong");

  c_hold_to_up: cover property (st_q == ST_HOLD ##1 st_q == ST_UP);
  c_clip_down: cover property (clip && apply && st_q == ST_DOWN);
  c_gated: cover property (gated && tmr_tick);
  c_limiter_switch: cover property (active && $rose(levelling_mode_select));
endmodule

// [dv/ilc_adc_model.sv]
// Amplifier and ADC stand-in: a square wave of bench-chosen level
`timescale 1ns/1ns
module ilc_adc_model
  import ilc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Level asked for by the bench
  input wire logic [ilc_pkg::SMP_W-1:0] amp,
  // Sample stream
  output logic [ilc_pkg::SMP_W-1:0] smp_l,
  output logic [ilc_pkg::SMP_W-1:0] smp_r,
  output logic smp_valid
);
  logic [1:0] div_q;
  logic sgn_q;
  // One sample every four clocks, sign flips so zero crossings occur
  always_ff @(posedge sys_clk)
  begin
    div_q <= srst ? 2'h0 : div_q + 2'h1;
    smp_valid <= !srst && div_q == 2'h3;
    sgn_q <= srst ? 1'b0 : sgn_q ^ (div_q == 2'h3);
  end
  assign smp_l = sgn_q ? -amp : amp;
  assign smp_r = smp_l;
endmodule

// [dv/test_ilc_top.sv]
// Self-checking bench of the input level controller
`timescale 1ns/1ns
module test_ilc_top;
  import ilc_pkg::*;
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, mwr = 0, smp_valid;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, d, exp_q[$];
  logic [SMP_W-1:0] amp = '0, smp_l, smp_r;
  logic [GAIN_W-1:0] man_l = '0, man_r = '0, mic = '0, pga_gain_l, pga_gain_r;
  int failures = 0, cmp_count = 0;
  // Clock
  always #2 sys_clk = ~sys_clk;
  ilc_adc_model u_adc (.sys_clk(sys_clk), .srst(srst), .amp(amp), .smp_l(smp_l), .smp_r(smp_r),
    .smp_valid(smp_valid));
  ilc_top u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_l(smp_l), .smp_r(smp_r),
    .smp_valid(smp_valid), .manual_input_gain_l(man_l), .manual_input_gain_r(man_r),
    .manual_gain_wr_l(mwr), .manual_gain_wr_r(mwr), .mic_boost_gain(mic),
    .pga_gain_l(pga_gain_l), .pga_gain_r(pga_gain_r));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [6:0] a, input logic [8:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    reg_rd <= 0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [6:0] a, input logic [8:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    reg_wr <= 0;
    exp_q.push_back(e);
    @(posedge sys_clk);
  endtask
  task idle(input int n);
    reg_rd <= 0;
    reg_wr <= 0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task man(input logic [5:0] gl, input logic [5:0] gr);
    man_l <= gl;
    man_r <= gr;
    mwr <= 1;
    @(posedge sys_clk);
    mwr <= 0;
  endtask
  task end_of_test;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data watcher: oldest expectation against the cycle after each read
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  // Watchdog
  initial
  begin
    #40000;
    failures++;
    end_of_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hf1b6f357));
    repeat (3) @(posedge sys_clk);
    srst <= 0;
    @(posedge sys_clk);
    // Reset values back to back, then an unmapped place
    rd(ADDR_CFG1, RST_CFG1);
    rd(ADDR_CFG2, RST_CFG2);
    rd(ADDR_CFG3, RST_CFG3);
    rd(ADDR_NG, RST_NG);
    rd(7'h30, 9'h000);
    // Random write and read back, gate register keeps bits 3:0 only
    for (int i = 0; i < 4; i++)
    begin
      d = 9'($urandom);
      wr(ADDR_CFG2, d);
      rd(ADDR_CFG2, d);
      wr(ADDR_NG, d);
      rd(ADDR_NG, {5'h00, d[3:0]});
    end
    wr(ADDR_CFG2, 9'h10b);
    wr(ADDR_CFG3, 9'h000);
    wr(ADDR_NG, 9'h000);
    // Control off: manual writes reach the amplifier
    man(6'h05, 6'h05);
    idle(4);
    chk("gain_off", {3'h0, pga_gain_l}, 9'h005);
    // Start below floor 0x18 is pulled into range at once
    wr(ADDR_CFG1, 9'h1bb);
    idle(3);
    chk("gain_l_clamp", {3'h0, pga_gain_l}, 9'h018);
    chk("gain_r_clamp", {3'h0, pga_gain_r}, 9'h018);
    // Silent input gives no zero crossing, so no step is taken
    idle(200);
    chk("gain_zc_wait", {3'h0, pga_gain_l}, 9'h018);
    // Quiet input raises gain
    amp <= 16'h0400;
    idle(400);
    chk("gain_rise", {8'h00, pga_gain_l > 6'h18}, 9'h001);
    // Near full scale ramps down to the floor
    amp <= 16'h7800;
    idle(300);
    chk("gain_fall", {3'h0, pga_gain_l}, 9'h018);
    // A 129-sample hold delays the rise once the loud burst ends
    wr(ADDR_CFG2, 9'h11b);
    amp <= 16'h0400;
    idle(300);
    chk("gain_hold", {3'h0, pga_gain_l}, 9'h018);
    idle(450);
    chk("gain_after_hold", {8'h00, pga_gain_l > 6'h18}, 9'h001);
    amp <= 16'h7800;
    idle(150);
    // Disable: gain kept, only manual writes change it
    wr(ADDR_CFG1, 9'h03b);
    idle(100);
    chk("gain_kept", {3'h0, pga_gain_l}, 9'h018);
    man(6'h08, 6'h02);
    idle(4);
    chk("gain_manual", {3'h0, pga_gain_r}, 9'h002);
    // Noise gate with mic boost, left channel only; right stays on manual gain
    man(6'h08, 6'h06);
    wr(ADDR_CFG2, 9'h10b);
    wr(ADDR_NG, 9'h008);
    mic <= 6'h20;
    amp <= 16'h0400;
    wr(ADDR_CFG1, 9'h13b);
    idle(300);
    chk("gain_gated", {3'h0, pga_gain_l}, 9'h018);
    chk("gain_r_manual", {3'h0, pga_gain_r}, 9'h006);
    mic <= 6'h00;
    idle(200);
    chk("gain_ungated", {8'h00, pga_gain_l > 6'h18}, 9'h001);
    wr(ADDR_NG, 9'h000);
    wr(ADDR_CFG1, 9'h03b);
    // Limiter mode never climbs above the start gain
    wr(ADDR_CFG3, 9'h100);
    wr(ADDR_CFG1, 9'h1b8);
    amp <= 16'h0400;
    idle(600);
    chk("gain_limit", {3'h0, pga_gain_l}, 9'h008);
    idle(2);
    end_of_test;
  end
endmodule
